// file: verilog/pmt_pkg.sv
// constants for the program store and table read block
// Contract
// - program store is 4K words of 16 bits, fetched at the program counter address.
// - any program word can be read as table data, no address restriction.
// - after any reset the first instruction fetch is from address 000H.
// - table read address comes from the low table pointer byte and the high byte's low 4 bits, or page FH when i_tbl_last_page is set.
// - extended table reads reach any data sector; standard ones reach sector 0.
// - table read writes the word's low byte to the operand's data location.
// - table read loads the word's high byte into the table-high register.
// - table-high bits with no program word bit read as zero.
// - every table read, standard or extended, takes two instruction cycles.
// - software can read and write the table-high register.
// - programming moves address and data serially on one data pin plus a clock pin.
package pmt_pkg;
    // =====================================
    // memory shape
    localparam int PM_DEPTH = 4096;
    localparam int PM_AW = 12;
    localparam int PM_DW = 16;
    localparam int DM_AW = 10;
    localparam int DM_SECT_W = 2;
    localparam int BYTE_W = 8;
    localparam int LO_POS = 0;
    localparam int HI_POS = 8;
    localparam int PAGE_W = 4;
    // =====================================
    // addresses and reset values
    localparam logic [11:0] RESET_VECTOR = 12'h000;
    localparam logic [3:0] LAST_PAGE = 4'hF;
    localparam logic [1:0] SECTOR0 = 2'h0;
    localparam logic [7:0] TP_RESET = 8'h00;
    localparam logic [7:0] THR_RESET = 8'h00;
    // high byte bits backed by the program word; all 8 for a 16-bit word
    localparam logic [7:0] THR_MASK = 8'hFF;
    // =====================================
    // serial programming frame: 1 direction bit, 12 address bits, 16 data bits
    localparam logic [5:0] ICP_HDR_BITS = 6'h0D;
    localparam logic [5:0] ICP_DATA_BITS = 6'h10;
    localparam logic ICP_CMD_READ = 1'b1;

    typedef enum logic [1:0] {TR_IDLE, TR_READ, TR_DONE} pmt_tr_state_e;
    typedef enum logic [1:0] {ICP_HDR, ICP_WDATA, ICP_RDATA} pmt_icp_state_e;
endpackage

// file: verilog/pmt_program_memory.sv
// program store with instruction fetch, table read and serial programming
`timescale 1ns/100ps
module pmt_program_memory (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // instruction fetch
    input wire logic [11:0] i_pc,
    output logic [11:0] o_fetch_addr,
    output logic [15:0] o_instr,
    // table pointer and table-high register access from the core
    input wire logic [7:0] i_wdata,
    input wire logic i_tp_lo_we,
    input wire logic i_tp_hi_we,
    input wire logic i_thr_we,
    output logic [7:0] o_tp_lo,
    output logic [7:0] o_tp_hi,
    output logic [7:0] o_table_high_result,
    // table read request
    input wire logic i_tbl_start,
    input wire logic i_extended_table_read_instr,
    input wire logic i_tbl_last_page,
    input wire logic [9:0] i_tbl_dest,
    // table read result to data memory
    output logic o_tbl_busy,
    output logic o_dm_we,
    output logic [9:0] o_dm_addr,
    output logic [7:0] o_dm_data,
    // serial programming pins
    input wire logic i_prog_mode,
    input wire logic i_prog_serial_clock_pin,
    input wire logic i_prog_serial_data_pin,
    output logic o_prog_serial_data_pin,
    output logic o_prog_serial_data_pin_oe
);
    // =====================================
    // storage
    logic [15:0] mem [0:pmt_pkg::PM_DEPTH-1];

    // =====================================
    // fetch
    logic boot_reg;
    wire [11:0] fetch_addr = boot_reg ? pmt_pkg::RESET_VECTOR : i_pc;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            boot_reg <= 1'b1;
            o_fetch_addr <= pmt_pkg::RESET_VECTOR;
            o_instr <= 16'h0000;
        end else begin
            boot_reg <= 1'b0;
            o_fetch_addr <= fetch_addr;
            o_instr <= mem[fetch_addr];
        end
    end

    // =====================================
    // table pointer
    logic [7:0] tp_lo_reg;
    logic [7:0] tp_hi_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            tp_lo_reg <= pmt_pkg::TP_RESET;
            tp_hi_reg <= pmt_pkg::TP_RESET;
        end else begin
            if (i_tp_lo_we) begin
                tp_lo_reg <= i_wdata;
            end
            if (i_tp_hi_we) begin
                tp_hi_reg <= i_wdata;
            end
        end
    end

    // =====================================
    // programming enable pin, synchronised before any logic reads it
    logic pm_s1_reg;
    logic pm_s2_reg;

    // =====================================
    // table read
    pmt_pkg::pmt_tr_state_e tr_state_reg;
    logic [11:0] tr_addr_reg;
    logic [9:0] tr_dest_reg;
    wire [3:0] tr_page = i_tbl_last_page ? pmt_pkg::LAST_PAGE : tp_hi_reg[3:0];
    wire [11:0] tr_addr = {tr_page, tp_lo_reg};
    wire [9:0] tr_dest = i_extended_table_read_instr ? i_tbl_dest
        : {pmt_pkg::SECTOR0, i_tbl_dest[7:0]};
    wire tr_take = (tr_state_reg == pmt_pkg::TR_IDLE) && i_tbl_start && !pm_s2_reg;
    wire [15:0] tr_word = mem[tr_addr_reg];
    wire [7:0] tr_hi = tr_word[pmt_pkg::HI_POS +: pmt_pkg::BYTE_W] & pmt_pkg::THR_MASK;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            tr_state_reg <= pmt_pkg::TR_IDLE;
            tr_addr_reg <= pmt_pkg::RESET_VECTOR;
            tr_dest_reg <= 10'h000;
        end else begin
            case (tr_state_reg)
                pmt_pkg::TR_IDLE: begin
                    if (tr_take) begin
                        tr_state_reg <= pmt_pkg::TR_READ;
                        tr_addr_reg <= tr_addr;
                        tr_dest_reg <= tr_dest;
                    end
                end
                pmt_pkg::TR_READ: begin
                    tr_state_reg <= pmt_pkg::TR_DONE;
                end
                default: begin
                    tr_state_reg <= pmt_pkg::TR_IDLE;
                end
            endcase
        end
    end

    wire tr_fire = (tr_state_reg == pmt_pkg::TR_READ);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_tbl_busy <= 1'b0;
            o_dm_we <= 1'b0;
            o_dm_addr <= 10'h000;
            o_dm_data <= 8'h00;
        end else begin
            o_tbl_busy <= tr_take || tr_fire;
            o_dm_we <= tr_fire;
            if (tr_fire) begin
                o_dm_addr <= tr_dest_reg;
                o_dm_data <= tr_word[pmt_pkg::LO_POS +: pmt_pkg::BYTE_W];
            end
        end
    end

    // table-high register; a completing table read wins over a software write
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_table_high_result <= pmt_pkg::THR_RESET;
        end else if (tr_fire) begin
            o_table_high_result <= tr_hi;
        end else if (i_thr_we) begin
            o_table_high_result <= i_wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_tp_lo <= pmt_pkg::TP_RESET;
            o_tp_hi <= pmt_pkg::TP_RESET;
        end else begin
            o_tp_lo <= tp_lo_reg;
            o_tp_hi <= tp_hi_reg;
        end
    end

    // =====================================
    // serial programming: pin synchronisers
    logic sck_s1_reg;
    logic sck_s2_reg;
    logic sck_s3_reg;
    logic sda_s1_reg;
    logic sda_s2_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_s3_reg <= 1'b0;
            sda_s1_reg <= 1'b0;
            sda_s2_reg <= 1'b0;
            pm_s1_reg <= 1'b0;
            pm_s2_reg <= 1'b0;
        end else begin
            sck_s1_reg <= i_prog_serial_clock_pin;
            sck_s2_reg <= sck_s1_reg;
            sck_s3_reg <= sck_s2_reg;
            sda_s1_reg <= i_prog_serial_data_pin;
            sda_s2_reg <= sda_s1_reg;
            pm_s1_reg <= i_prog_mode;
            pm_s2_reg <= pm_s1_reg;
        end
    end

    wire sck_rise = sck_s2_reg && !sck_s3_reg;
    wire sck_fall = !sck_s2_reg && sck_s3_reg;

    // =====================================
    // serial programming: frame engine
    pmt_pkg::pmt_icp_state_e icp_state_reg;
    logic [5:0] icp_cnt_reg;
    logic [12:0] icp_hdr_reg;
    logic [15:0] icp_sh_reg;
    logic icp_we_reg;
    wire [11:0] icp_addr = icp_hdr_reg[11:0];
    wire icp_hdr_last = (icp_cnt_reg == pmt_pkg::ICP_HDR_BITS - 6'h01);
    wire icp_data_last = (icp_cnt_reg == pmt_pkg::ICP_DATA_BITS - 6'h01);
    wire [12:0] icp_hdr_next = {icp_hdr_reg[11:0], sda_s2_reg};
    wire icp_is_read = (icp_hdr_next[12] == pmt_pkg::ICP_CMD_READ);

    always_ff @(posedge i_core_clk) begin
        if (i_rst || !pm_s2_reg) begin
            icp_state_reg <= pmt_pkg::ICP_HDR;
            icp_cnt_reg <= 6'h00;
            icp_hdr_reg <= 13'h0000;
            icp_sh_reg <= 16'h0000;
            icp_we_reg <= 1'b0;
        end else begin
            icp_we_reg <= 1'b0;
            case (icp_state_reg)
                pmt_pkg::ICP_HDR: begin
                    if (sck_rise) begin
                        icp_hdr_reg <= icp_hdr_next;
                        icp_cnt_reg <= icp_hdr_last ? 6'h00 : icp_cnt_reg + 6'h01;
                        if (icp_hdr_last) begin
                            icp_state_reg <= icp_is_read ? pmt_pkg::ICP_RDATA
                                : pmt_pkg::ICP_WDATA;
                            icp_sh_reg <= mem[icp_hdr_next[11:0]];
                        end
                    end
                end
                pmt_pkg::ICP_WDATA: begin
                    if (sck_rise) begin
                        icp_sh_reg <= {icp_sh_reg[14:0], sda_s2_reg};
                        icp_cnt_reg <= icp_data_last ? 6'h00 : icp_cnt_reg + 6'h01;
                        if (icp_data_last) begin
                            icp_we_reg <= 1'b1;
                            icp_state_reg <= pmt_pkg::ICP_HDR;
                        end
                    end
                end
                default: begin
                    if (sck_rise) begin
                        icp_sh_reg <= {icp_sh_reg[14:0], 1'b0};
                        icp_cnt_reg <= icp_data_last ? 6'h00 : icp_cnt_reg + 6'h01;
                        if (icp_data_last) begin
                            icp_state_reg <= pmt_pkg::ICP_HDR;
                        end
                    end
                end
            endcase
        end
    end

    // programming write port into the store
    always_ff @(posedge i_core_clk) begin
        if (icp_we_reg) begin
            mem[icp_addr] <= icp_sh_reg;
        end
    end

    // data pin is driven only during a read data phase, msb first
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_prog_serial_data_pin <= 1'b0;
            o_prog_serial_data_pin_oe <= 1'b0;
        end else begin
            o_prog_serial_data_pin_oe <= pm_s2_reg
                && (icp_state_reg == pmt_pkg::ICP_RDATA);
            if (sck_fall || icp_state_reg != pmt_pkg::ICP_RDATA) begin
                o_prog_serial_data_pin <= icp_sh_reg[15];
            end
        end
    end
endmodule

// file: verif/pmt_program_memory_sva.sv
// checker for the program store table read and fetch ports
`timescale 1ns/100ps
module pmt_program_memory_chk (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // watched ports
    input wire logic [11:0] i_pc,
    input wire logic [11:0] o_fetch_addr,
    input wire logic i_thr_we,
    input wire logic [7:0] o_table_high_result,
    input wire logic i_extended_table_read_instr,
    input wire logic [9:0] i_tbl_dest,
    input wire logic o_tbl_busy,
    input wire logic o_dm_we,
    input wire logic [9:0] o_dm_addr
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // ==========
    // table read steps, table-high cause and fetch address
    sequence s_rd_start; $rose(o_tbl_busy); endsequence
    sequence s_rd_body; o_tbl_busy [*2] ##1 !o_tbl_busy; endsequence
    chk_busy_two_cyc: assert property (s_rd_start |-> s_rd_body)
        else $error("busy length wrong");
    chk_write_after_start: assert property (s_rd_start |-> !o_dm_we ##1 o_dm_we)
        else $error("data write late");
    chk_write_in_busy: assert property (o_dm_we |-> o_tbl_busy)
        else $error("data write outside busy");
    chk_write_once: assert property (o_dm_we |=> !o_dm_we)
        else $error("data write too long");
    chk_std_sector: assert property (s_rd_start ##0 !$past(i_extended_table_read_instr, 1) |-> ##1 o_dm_addr[9:8] == 2'h0)
        else $error("standard read left sector");
    chk_ext_dest: assert property (s_rd_start ##0 $past(i_extended_table_read_instr, 1) |-> ##1 o_dm_addr == $past(i_tbl_dest, 2))
        else $error("extended dest wrong");
    chk_thr_cause: assert property ($changed(o_table_high_result) |-> $past(i_thr_we) || o_dm_we)
        else $error("table high changed alone");
    chk_reset_vector: assert property (!i_rst && $past(i_rst) |=> o_fetch_addr == 12'h000)
        else $error("first fetch not at vector");
    chk_fetch_pc: assert property (!i_rst && !$past(i_rst) |=> o_fetch_addr == $past(i_pc))
        else $error("fetch address not pc");
endmodule
bind pmt_program_memory pmt_program_memory_chk i_chk (.i_core_clk, .i_rst, .i_pc, .o_fetch_addr,
    .i_thr_we, .o_table_high_result, .i_extended_table_read_instr, .i_tbl_dest, .o_tbl_busy,
    .o_dm_we, .o_dm_addr);

// file: verif/pmt_dm_model.sv
// data memory model taking table read results
`timescale 1ns/100ps
module pmt_dm_model (
    // clock
    input wire logic i_core_clk,
    // write port
    input wire logic i_dm_we,
    input wire logic [9:0] i_dm_addr,
    input wire logic [7:0] i_dm_data
);
    logic [7:0] mem [1024];
    always @(posedge i_core_clk) begin
        if (i_dm_we) begin
            mem[i_dm_addr] <= i_dm_data;
        end
    end
endmodule

// file: verif/tb.sv
// self-checking bench for the program store and table read block
`timescale 1ns/100ps
module tb;
    logic i_core_clk = 0, i_rst = 1, i_prog_mode = 0, i_prog_serial_clock_pin = 0;
    logic i_prog_serial_data_pin = 0, i_tp_lo_we = 0, i_tp_hi_we = 0, i_thr_we = 0;
    logic i_tbl_start = 0, i_extended_table_read_instr = 0, i_tbl_last_page = 0;
    logic [11:0] i_pc = 0, o_fetch_addr;
    logic [7:0] i_wdata = 0, o_tp_lo, o_tp_hi, o_table_high_result, o_dm_data, m_lo, m_hi;
    logic [9:0] i_tbl_dest = 0, o_dm_addr;
    logic [15:0] o_instr;
    logic o_tbl_busy, o_dm_we, o_prog_serial_data_pin, o_prog_serial_data_pin_oe;
    int err_total = 0, checks_done = 0, cyc = 0;
    logic [15:0] ref_pm [int];
    logic [11:0] q [$] = '{12'h000, 12'hF05, 12'hF06, 12'hFFF, 12'h3A7};
    pmt_program_memory i_dut (.i_core_clk, .i_rst, .i_pc, .o_fetch_addr, .o_instr, .i_wdata,
        .i_tp_lo_we, .i_tp_hi_we, .i_thr_we, .o_tp_lo, .o_tp_hi, .o_table_high_result,
        .i_tbl_start, .i_extended_table_read_instr, .i_tbl_last_page, .i_tbl_dest, .o_tbl_busy,
        .o_dm_we, .o_dm_addr, .o_dm_data, .i_prog_mode, .i_prog_serial_clock_pin,
        .i_prog_serial_data_pin, .o_prog_serial_data_pin, .o_prog_serial_data_pin_oe);
    pmt_dm_model i_dm (.i_core_clk, .i_dm_we(o_dm_we), .i_dm_addr(o_dm_addr),
        .i_dm_data(o_dm_data));
    always #5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            end_of_test();
        end
    end
    // ==========
    // helpers
    task end_of_test;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(string n, logic [15:0] s, logic [15:0] e);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task cy(int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    // one programming clock period; data pin and enable are sampled just before the rise
    task pbit(logic b, output logic r, output logic o);
        i_prog_serial_data_pin = b;
        cy(4);
        r = o_prog_serial_data_pin;
        o = o_prog_serial_data_pin_oe;
        i_prog_serial_clock_pin = 1;
        cy(4);
        i_prog_serial_clock_pin = 0;
    endtask
    // frame: direction, address, data, msb first; a read compares the word shifted out
    task pframe(logic rd, logic [11:0] a, logic [15:0] d);
        logic r;
        logic o;
        logic [15:0] w;
        logic [15:0] ob;
        i_prog_mode = 1;
        pbit(rd, r, o);
        for (int i = 11; i >= 0; i--) pbit(a[i], r, o);
        for (int i = 15; i >= 0; i--) pbit(d[i], w[i], ob[i]);
        cy(6);
        chk("poe", ob, rd ? 16'hFFFF : 16'h0000);
        if (rd) chk("pdata", w, ref_pm[a]);
        else ref_pm[a] = d;
    endtask
    task wr(int k, logic [7:0] v);
        i_wdata = v;
        i_tp_lo_we = k == 0;
        i_tp_hi_we = k == 1;
        i_thr_we = k == 2;
        cy(1);
        {i_tp_lo_we, i_tp_hi_we, i_thr_we} = 3'h0;
        cy(1);
        if (k == 0) m_lo = v;
        if (k == 1) m_hi = v;
        chk("reg", k == 0 ? o_tp_lo : k == 1 ? o_tp_hi : o_table_high_result, v);
    endtask
    // second start while busy carries a wrong dest and must be ignored
    task rd(logic e, logic l, logic [9:0] d);
        logic [11:0] a;
        logic [9:0] xd;
        a = l ? {4'hF, m_lo} : {m_hi[3:0], m_lo};
        xd = e ? d : {2'h0, d[7:0]};
        i_dm.mem[xd] = ~ref_pm[a][7:0];
        {i_extended_table_read_instr, i_tbl_last_page, i_tbl_dest, i_tbl_start} = {e, l, d, 1'b1};
        cy(1);
        i_tbl_dest = ~d;
        cy(1);
        i_tbl_start = 0;
        cy(1);
        chk("dm", i_dm.mem[xd], ref_pm[a][7:0]);
        chk("thr", o_table_high_result, ref_pm[a][15:8]);
    endtask
    // ==========
    // main sequence
    initial begin
        logic [11:0] a;
        logic l;
        void'($urandom(5));
        cy(5);
        i_rst = 0;
        foreach (q[i]) pframe(1'b0, q[i], 16'($urandom));
        pframe(1'b1, q[3], 16'($urandom));
        i_prog_mode = 0;
        cy(4);
        foreach (ref_pm[k]) begin
            i_pc = 12'(k);
            cy(1);
            chk("instr", o_instr, ref_pm[k]);
            chk("faddr", o_fetch_addr, 16'(k));
        end
        i_rst = 1;
        cy(2);
        i_rst = 0;
        cy(1);
        chk("rstvec", o_fetch_addr, 16'h0000);
        chk("rstins", o_instr, ref_pm[0]);
        for (int i = 0; i < 10; i++) begin
            a = q[i % 5];
            l = a[11:8] == 4'hF && i[0];
            wr(0, a[7:0]);
            wr(1, l ? 8'($urandom) : {4'($urandom), a[11:8]});
            rd(i[1], l, 10'($urandom));
        end
        rd(1'b0, 1'b0, 10'($urandom));
        rd(1'b1, 1'b0, 10'($urandom));
        wr(2, 8'($urandom));
        end_of_test();
    end
endmodule
